// File: src/fbs_fault_brake_sequencer.sv
// fbs_fault_brake_sequencer: brake, energise and regen resistor sequencing on drive faults
// assumes speed and bus voltage come from logic on core_clk; fault pins are asynchronous
//
// Notes on behaviour
// RULE1: class-1 fault: brake off at speed threshold
// RULE2: class-1 fault: brake off at timeout expiry
// RULE3: class-2 with brake forces zero-speed stop
// RULE4: class-2: brake off once speed below 20 RPM
// RULE5: class-2: stay energised for static delay
// RULE6: resistor switched in at braking voltage
// RULE7: installer selects internal or external, never both
// RULE8: static delay counts ms from brake off
// RULE9: delays are ms counters checked every cycle
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "fbs_defines.svh"
module fbs_fault_brake_sequencer
   import fbs_pkg::*;
#(
   parameter int unsigned MS_CYCLES = `FBS_MS_CYCLES
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // fault pins, asynchronous
   input  wire logic        fault1Pin,
   input  wire logic        fault2Pin,
   // measurements from the control loop
   input  wire logic [15:0] motorSpeed,
   input  wire logic [15:0] busVoltage,
   // power stage and brake
   output fbs_drive_t       drive
);
   ////////////////////////////////////////////////////////////////////////////////
   // declarations
   fbs_ctrl_t   ctrl;                            // control register
   logic [15:0] static_deenergize_delay;         // ms, class-2 energised hold
   logic [15:0] rotating_brake_speed_threshold;  // rpm, class-1 release speed
   logic [15:0] rotating_brake_timeout;          // ms, class-1 release timeout
   logic [15:0] brakeVolt;                       // bus braking threshold
   logic [15:0] external_resistor_min_ohms;      // stored for software only
   fbs_state_t  state;                           // sequencer state
   fbs_state_t  next_state;                      // its next value
   logic        holdClass2;                      // hold entered from class-2 stop
   logic [1:0]  syncA;                           // first sync stage
   logic [1:0]  syncB;                           // second sync stage
   logic        fault1;                          // synchronised class-1 fault
   logic        fault2;                          // synchronised class-2 fault
   logic        rotStart;                        // start pulse, rotating timeout
   logic        rotExpired;                      // rotating timeout reached
   logic        holdStart;                       // start pulse, hold delay
   logic        holdExpired;                     // hold delay reached
   logic [15:0] holdLimit;                       // hold length in ms
   logic        wrPend;                          // write data phase pending
   logic [7:0]  wrAddr;                          // latched write offset
   logic        addrOk;                          // address phase taken
   logic [31:0] rdMux;                           // read data for the offset

   ////////////////////////////////////////////////////////////////////////////////
   // fault pin synchronisers, one per pin
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               syncA[gi] <= 1'b0;
               syncB[gi] <= 1'b0;
            end else begin
               syncA[gi] <= (gi == 0) ? fault1Pin : fault2Pin;
               syncB[gi] <= syncA[gi];
            end
         end
      end
   endgenerate
   assign fault1 = syncB[0];
   assign fault2 = syncB[1];

   ////////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave, zero wait states
   assign addrOk = hsel && htrans[1] && hready;

   // always ready and okay; no transfer here needs stretching
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // latch write address phase for the following data phase
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wrPend <= 1'b0;
         wrAddr <= 8'h00;
      end else if (hready) begin
         wrPend <= addrOk && hwrite;
         wrAddr <= haddr[7:0];
      end
   end

   // read decode; unmapped offsets read zero
   always_comb begin
      rdMux = 32'h0000_0000;
      case (haddr[7:0])
         `FBS_OFS_CTRL:       rdMux = {29'h0000_0000, ctrl.selExt, ctrl.selInt, ctrl.brakeUse};
         `FBS_OFS_STATIC_DLY: rdMux = {16'h0000, static_deenergize_delay};
         `FBS_OFS_SPEED_THR:  rdMux = {16'h0000, rotating_brake_speed_threshold};
         `FBS_OFS_ROT_TMO:    rdMux = {16'h0000, rotating_brake_timeout};
         `FBS_OFS_BRAKE_VOLT: rdMux = {16'h0000, brakeVolt};
         `FBS_OFS_EXT_OHMS:   rdMux = {16'h0000, external_resistor_min_ohms};
         `FBS_OFS_STATUS:     rdMux = {21'h00_0000, holdClass2, fault2, fault1, state, drive};
         default:             rdMux = 32'h0000_0000;
      endcase
   end

   // read data registered at the address phase, stands for the data phase
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         hrdata <= 32'h0000_0000;
      end else if (addrOk && !hwrite) begin
         hrdata <= rdMux;
      end
   end

   // register writes in the data phase; fault clear is a one-cycle pulse
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl                           <= `FBS_RST_CTRL;
         static_deenergize_delay        <= `FBS_RST_STATIC_DLY;
         rotating_brake_speed_threshold <= `FBS_RST_SPEED_THR;
         rotating_brake_timeout         <= `FBS_RST_ROT_TMO;
         brakeVolt                      <= `FBS_RST_BRAKE_VOLT;
         external_resistor_min_ohms     <= `FBS_RST_EXT_OHMS;
      end else begin
         ctrl.faultClear <= 1'b0;
         if (wrPend) begin
            case (wrAddr)
               `FBS_OFS_CTRL:       ctrl <= fbs_ctrl_t'(hwdata[3:0]);
               `FBS_OFS_STATIC_DLY: static_deenergize_delay <= hwdata[15:0];
               `FBS_OFS_SPEED_THR:  rotating_brake_speed_threshold <= hwdata[15:0];
               `FBS_OFS_ROT_TMO:    rotating_brake_timeout <= hwdata[15:0];
               `FBS_OFS_BRAKE_VOLT: brakeVolt <= hwdata[15:0];
               `FBS_OFS_EXT_OHMS:   external_resistor_min_ohms <= hwdata[15:0];
               default:             ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // delay timers
   assign rotStart  = (next_state == FBS_F1WT) && (state != FBS_F1WT);  // [RULE9]
   assign holdStart = (next_state == FBS_HOLD) && (state != FBS_HOLD);  // [RULE8]
   // class-1 hold keeps the fixed rotating-stop figure
   assign holdLimit = holdClass2 ? static_deenergize_delay : `FBS_ROT_HOLD_MS;

   fbs_ms_timer #(.MS_CYCLES(MS_CYCLES)) u_rot_timer (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .start    (rotStart),
      .limitMs  (rotating_brake_timeout),
      .expired  (rotExpired)
   );

   fbs_ms_timer #(.MS_CYCLES(MS_CYCLES)) u_hold_timer (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .start    (holdStart),
      .limitMs  (holdLimit),
      .expired  (holdExpired)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer; class-2 outranks class-1
   always_comb begin
      next_state = state;
      case (state)
         FBS_RUN: begin
            if (fault2) begin
               next_state = ctrl.brakeUse ? FBS_F2DC : FBS_DEEN;  // [RULE3]
            end else if (fault1) begin
               next_state = ctrl.brakeUse ? FBS_F1WT : FBS_DEEN;
            end
         end
         FBS_F1WT: begin
            if (fault2) begin
               next_state = FBS_F2DC;  // [RULE3]
            end else if (motorSpeed <= rotating_brake_speed_threshold) begin
               next_state = FBS_HOLD;  // [RULE1]
            end else if (rotExpired) begin
               next_state = FBS_HOLD;  // [RULE2]
            end
         end
         FBS_F2DC: begin
            // zero-speed stop runs until the motor is static
            if (motorSpeed < `FBS_STATIC_RPM) begin
               next_state = FBS_HOLD;  // [RULE4]
            end
         end
         FBS_HOLD: begin
            if (holdExpired) begin
               next_state = FBS_DEEN;  // [RULE5]
            end
         end
         FBS_DEEN: begin
            // only software brings the drive back, and only with faults gone
            if (ctrl.faultClear && !fault1 && !fault2) begin
               next_state = FBS_RUN;
            end
         end
         default: next_state = FBS_DEEN;
      endcase
   end

   // state register
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= FBS_RUN;
      end else begin
         state <= next_state;
      end
   end

   // remember which fault class opened the hold
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         holdClass2 <= 1'b0;
      end else if (holdStart) begin
         holdClass2 <= (state == FBS_F2DC);  // [RULE5]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs, all from flops
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         drive.brakeOutput   <= 1'b0;
         drive.driveEnable   <= 1'b0;
         drive.zeroSpeedStop <= 1'b0;
         drive.intResistorOn <= 1'b0;
         drive.extResistorOn <= 1'b0;
      end else begin
         drive.brakeOutput   <= (next_state == FBS_RUN) || (next_state == FBS_F1WT)
                                || (next_state == FBS_F2DC);  // [RULE1] [RULE2] [RULE4]
         drive.driveEnable   <= (next_state != FBS_DEEN);  // [RULE5]
         drive.zeroSpeedStop <= (next_state == FBS_F2DC);  // [RULE3]
         // regen gate shares this process so drive keeps a single writer;
         // a double selection is refused rather than burn both
         drive.intResistorOn <= (busVoltage >= brakeVolt) && ctrl.selInt
                                && !ctrl.selExt;  // [RULE6] [RULE7]
         drive.extResistorOn <= (busVoltage >= brakeVolt) && ctrl.selExt
                                && !ctrl.selInt;  // [RULE6] [RULE7]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_f2_entry;
      ((state == FBS_RUN) || (state == FBS_F1WT)) && fault2 && ctrl.brakeUse;
   endsequence
   sequence s_static;
      (state == FBS_F2DC) && (motorSpeed < `FBS_STATIC_RPM);
   endsequence

   a_f1_speed_release: assert property ((state == FBS_F1WT) && !fault2 && // [RULE1]
      (motorSpeed <= rotating_brake_speed_threshold) |=> !drive.brakeOutput)
      else $error("class-1 brake not dropped at speed threshold");
   a_f1_timeout_release: assert property ((state == FBS_F1WT) && !fault2 && // [RULE2]
      rotExpired |=> !drive.brakeOutput && drive.driveEnable)
      else $error("class-1 brake not dropped at timeout");
   a_f2_stop_override: assert property (s_f2_entry |=> drive.zeroSpeedStop && // [RULE3]
      drive.brakeOutput)
      else $error("class-2 fault did not force zero-speed stop");
   a_f2_static_brake: assert property (s_static |=> !drive.brakeOutput && // [RULE4]
      drive.driveEnable && (state == FBS_HOLD))
      else $error("class-2 brake not dropped below static speed");
   a_f2_brake_held: assert property ((state == FBS_F2DC) && // [RULE4]
      (motorSpeed >= `FBS_STATIC_RPM) |=> drive.brakeOutput)
      else $error("class-2 brake dropped while still turning");
   a_hold_energised: assert property ((state == FBS_HOLD) && !holdExpired |=> // [RULE5]
      drive.driveEnable)
      else $error("motor de-energised before hold delay");
   a_hold_end_off: assert property ((state == FBS_HOLD) && holdExpired |=> // [RULE8]
      !drive.driveEnable ##1 !drive.brakeOutput)
      else $error("motor still energised after hold delay");
   a_regen_gate: assert property ((busVoltage >= brakeVolt) && ctrl.selInt && // [RULE6]
      !ctrl.selExt |=> drive.intResistorOn)
      else $error("resistor not switched in at braking voltage");
   a_regen_single: assert property (!(drive.intResistorOn && drive.extResistorOn)) // [RULE7]
      else $error("both regen resistors switched in");
   a_timer_restart: assert property ($rose(state == FBS_HOLD) |-> !holdExpired && // [RULE9]
      $past(holdStart))
      else $error("hold timer not restarted on entry");
endmodule : fbs_fault_brake_sequencer

// File: src/fbs_defines.svh
// fbs_defines.svh: offsets, reset values and timing counts of the fault brake sequencer
// assumes a 100 MHz core clock and a 32-bit AHB-Lite register window
`ifndef FBS_DEFINES_SVH
`define FBS_DEFINES_SVH
// register byte offsets
`define FBS_OFS_CTRL        8'h00
`define FBS_OFS_STATIC_DLY  8'h04
`define FBS_OFS_SPEED_THR   8'h08
`define FBS_OFS_ROT_TMO     8'h0C
`define FBS_OFS_BRAKE_VOLT  8'h10
`define FBS_OFS_EXT_OHMS    8'h14
`define FBS_OFS_STATUS      8'h18
// reset values
`define FBS_RST_CTRL        4'h0
`define FBS_RST_STATIC_DLY  16'h0096
`define FBS_RST_SPEED_THR   16'h001E
`define FBS_RST_ROT_TMO     16'h01F4
`define FBS_RST_BRAKE_VOLT  16'h0186
`define FBS_RST_EXT_OHMS    16'h0000
// fixed figures
`define FBS_STATIC_RPM      16'h0014
`define FBS_ROT_HOLD_MS     16'h0032
// timing: one millisecond tick
`define FBS_MS_NS           1000000
`define FBS_CLK_NS          10
`define FBS_MS_CYCLES       (`FBS_MS_NS / `FBS_CLK_NS)
`endif

// File: src/fbs_pkg.sv
// fbs_pkg: types shared by the fault brake sequencer files
// assumes nothing beyond the defines header
package fbs_pkg;
   // sequencer states, gray along run -> wait -> decel -> hold -> off
   typedef enum logic [2:0] {
      FBS_RUN   = 3'h0,
      FBS_F1WT  = 3'h1,
      FBS_F2DC  = 3'h3,
      FBS_HOLD  = 3'h2,
      FBS_DEEN  = 3'h6
   } fbs_state_t;

   // software control bits
   typedef struct packed {
      logic faultClear;   // write-one pulse, leaves the off state
      logic selExt;       // external resistor fitted
      logic selInt;       // internal resistor fitted
      logic brakeUse;     // holding brake function in use
   } fbs_ctrl_t;

   // drive-side outputs
   typedef struct packed {
      logic brakeOutput;    // high releases the holding brake
      logic driveEnable;    // motor energised
      logic zeroSpeedStop;  // forced zero-speed stop command
      logic intResistorOn;  // internal regen resistor switched in
      logic extResistorOn;  // external regen resistor switched in
   } fbs_drive_t;
endpackage : fbs_pkg

// File: src/fbs_ms_timer.sv
// fbs_ms_timer: millisecond-tick delay counter with restart and registered expiry
// assumes start is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps
`include "fbs_defines.svh"
module fbs_ms_timer #(
   parameter int unsigned MS_CYCLES = `FBS_MS_CYCLES
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // control
   input  wire logic        start,
   input  wire logic [15:0] limitMs,
   // status
   output logic             expired
);
   logic [31:0] preCount;   // cycles within the current millisecond
   logic [15:0] msCount;    // whole milliseconds since start
   logic        msTick;     // last cycle of a millisecond

   assign msTick = (preCount == MS_CYCLES - 1);

   // prescaler, restarted so the first millisecond is a full one
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         preCount <= 32'h0000_0000;
      end else if (start || msTick) begin
         preCount <= 32'h0000_0000;
      end else begin
         preCount <= preCount + 32'h0000_0001;
      end
   end

   // millisecond count, saturates instead of wrapping back below the limit
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         msCount <= 16'h0000;
      end else if (start) begin
         msCount <= 16'h0000;
      end else if (msTick && msCount != 16'hFFFF) begin
         msCount <= msCount + 16'h0001;
      end
   end

   // expiry judged every cycle against the live limit
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         expired <= 1'b0;
      end else if (start) begin
         expired <= 1'b0;
      end else begin
         expired <= (msCount >= limitMs);
      end
   end
endmodule : fbs_ms_timer

// File: dv/fbs_motor_model.sv
// fbs_motor_model: behavioural motor, holding brake and dc bus facing the sequencer
// assumes the bench loads speed, deceleration step and bus voltage on core_clk
`timescale 1ns/1ps
module fbs_motor_model
   import fbs_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // commands from the sequencer
   input  wire fbs_drive_t  drive,
   // bench controls
   input  wire logic        loadSpeed,
   input  wire logic [15:0] speedIn,
   input  wire logic [15:0] decStep,
   input  wire logic [15:0] voltIn,
   // measurements back to the sequencer
   output logic [15:0]      motorSpeed,
   output logic [15:0]      busVoltage
);
   ////////////////////////////////////////////////////////////////////////////////
   // shaft speed: bench load wins, else ramps down while stopping or unpowered
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         motorSpeed <= 16'h0000;
      end else if (loadSpeed) begin
         motorSpeed <= speedIn;
      end else if (!drive.brakeOutput && !drive.driveEnable) begin
         // brake clamped and no torque: the shaft is held still
         motorSpeed <= 16'h0000;
      end else if (drive.zeroSpeedStop || !drive.driveEnable) begin
         // saturate so the ramp never wraps to a huge speed
         motorSpeed <= (motorSpeed > decStep) ? motorSpeed - decStep : 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus voltage: one register stage, like a sampled measurement
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         busVoltage <= 16'h0000;
      end else begin
         busVoltage <= voltIn;
      end
   end
endmodule : fbs_motor_model

// File: dv/fbs_fault_brake_sequencer_tb_top.sv
// fbs_fault_brake_sequencer_tb_top: self-checking bench for the fault brake sequencer
// assumes the sequencer runs with a 10-cycle millisecond so delays stay short
`timescale 1ns/1ps
`include "fbs_defines.svh"
module fbs_fault_brake_sequencer_tb_top
   import fbs_pkg::*;
;
   typedef struct packed {
      logic [31:0] a;   // byte address
      logic [31:0] d;   // data written
      logic [31:0] e;   // value read back
   } fbs_tbrow_t;
   // clock, reset, bus and pins
   logic        core_clk, rst_b, hsel, hwrite, hreadyout, hresp, fault1Pin, fault2Pin;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [15:0] motorSpeed, busVoltage, speedIn, voltIn;
   logic        loadSpeed;
   fbs_drive_t  drive;
   int          n_fail, checked, n;
   // register rows: write, read back
   fbs_tbrow_t  rows [8] = '{
      '{32'h0000_0000, 32'h0000_000F, 32'h0000_0007},  // pulse bit reads 0
      '{32'h0000_0004, 32'hFFFF_0003, 32'h0000_0003},  // upper half dropped
      '{32'h0000_0008, 32'h0000_001E, 32'h0000_001E},
      '{32'h0000_000C, 32'h0000_0004, 32'h0000_0004},
      '{32'h0000_0010, 32'h0000_0100, 32'h0000_0100},
      '{32'h0000_0014, 32'h0000_0028, 32'h0000_0028},
      '{32'h0000_001C, 32'h0000_1234, 32'h0000_0000},  // unmapped
      '{32'h0000_0020, 32'h0000_5555, 32'h0000_0000}}; // unmapped

   ////////////////////////////////////////////////////////////////////////////////
   fbs_fault_brake_sequencer #(.MS_CYCLES(10)) dut_u (
      .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .fault1Pin(fault1Pin), .fault2Pin(fault2Pin), .motorSpeed(motorSpeed),
      .busVoltage(busVoltage), .drive(drive));
   fbs_motor_model motor_u (
      .core_clk(core_clk), .rst_b(rst_b), .drive(drive), .loadSpeed(loadSpeed),
      .speedIn(speedIn), .decStep(16'h0000), .voltIn(voltIn),
      .motorSpeed(motorSpeed), .busVoltage(busVoltage));

   ////////////////////////////////////////////////////////////////////////////////
   // shared helpers
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task close_out;
      if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   task ahb_write(input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1; haddr <= a; hwrite <= 1'b1; htrans <= 2'h2;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
   endtask : ahb_write
   task ahb_read(input logic [31:0] a, output logic [31:0] q);
      @(posedge core_clk);
      hsel <= 1'b1; haddr <= a; hwrite <= 1'b0; htrans <= 2'h2;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      q = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask : ahb_read
   // cycles until one drive bit reaches a level, capped at maxc
   task wait_drv(input int idx, input logic v, input int maxc, output int c);
      c = 0;
      while (drive[idx] !== v && c < maxc) begin
         @(posedge core_clk);
         c++;
      end
   endtask : wait_drv
   task set_speed(input logic [15:0] v);
      @(posedge core_clk);
      speedIn <= v; loadSpeed <= 1'b1;
      @(posedge core_clk);
      loadSpeed <= 1'b0;
   endtask : set_speed
   // drop faults and clear back to run with brake and internal resistor
   task recover;
      @(posedge core_clk);
      fault1Pin <= 1'b0; fault2Pin <= 1'b0;
      repeat (4) @(posedge core_clk);
      ahb_write(32'h0000_0000, 32'h0000_000B);
      repeat (2) @(posedge core_clk);
      check(drive[4:3], 2'b11);
   endtask : recover

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // watchdog: the sequence needs about 1300 cycles
   initial begin
      repeat (30000) @(posedge core_clk);
      n_fail++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      n_fail = 0; checked = 0; rst_b = 1'b0; hsel = 1'b0; hwrite = 1'b0;
      htrans = 2'h0; haddr = 32'h0; hwdata = 32'h0; fault1Pin = 1'b0;
      fault2Pin = 1'b0; speedIn = 16'h0; voltIn = 16'h0; loadSpeed = 1'b0;
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      // ordinary register rows
      foreach (rows[i]) begin
         ahb_write(rows[i].a, rows[i].d);
         ahb_read(rows[i].a, rd);
         check(rd, rows[i].e);
      end
      // second reset in mid-run restores every default
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      ahb_read(32'h0000_0000, rd); check(rd, 32'h0000_0000);
      ahb_read(32'h0000_0004, rd); check(rd, {16'h0, `FBS_RST_STATIC_DLY});
      ahb_read(32'h0000_0008, rd); check(rd, {16'h0, `FBS_RST_SPEED_THR});
      ahb_read(32'h0000_000C, rd); check(rd, {16'h0, `FBS_RST_ROT_TMO});
      ahb_read(32'h0000_0010, rd); check(rd, {16'h0, `FBS_RST_BRAKE_VOLT});
      ahb_read(32'h0000_0014, rd); check(rd, {16'h0, `FBS_RST_EXT_OHMS});
      // status is read-only: run state, brake released, energised
      ahb_write(32'h0000_0018, 32'h0000_FFFF);
      ahb_read(32'h0000_0018, rd); check(rd, 32'h0000_0018);
      // short delays: static 3 ms, timeout 4 ms, threshold 30 rpm
      ahb_write(32'h0000_0000, 32'h0000_0003);
      ahb_write(32'h0000_0004, 32'h0000_0003);
      ahb_write(32'h0000_000C, 32'h0000_0004);
      ahb_write(32'h0000_0010, 32'h0000_0100);
      // regen resistor gating on bus voltage
      voltIn <= 16'h00FF;
      repeat (4) @(posedge core_clk);
      check(drive[1:0], 2'b00);
      voltIn <= 16'h0100;
      repeat (4) @(posedge core_clk);
      check(drive[1:0], 2'b10);
      ahb_write(32'h0000_0000, 32'h0000_0007); // both fitted: a wiring fault
      repeat (3) @(posedge core_clk);
      check(drive[1:0], 2'b00);
      ahb_write(32'h0000_0000, 32'h0000_0005); // external only
      repeat (3) @(posedge core_clk);
      check(drive[1:0], 2'b01);
      ahb_write(32'h0000_0000, 32'h0000_0003);
      voltIn <= 16'h0000;
      // class 1, speed falls to the threshold before the timeout
      set_speed(16'd31);
      fault1Pin <= 1'b1;
      repeat (20) @(posedge core_clk);
      check(drive[4], 1'b1);
      set_speed(16'd30);
      wait_drv(4, 1'b0, 5, n);
      check(n < 5, 1'b1);
      check(drive[3], 1'b1);
      wait_drv(3, 1'b0, 600, n);
      check(n >= 480 && n <= 520, 1'b1);
      recover();
      // class 1, speed stays high: the timeout releases the brake
      set_speed(16'd1000);
      @(posedge core_clk);
      fault1Pin <= 1'b1;
      wait_drv(4, 1'b0, 100, n);
      check(n >= 40 && n <= 48, 1'b1);
      wait_drv(3, 1'b0, 600, n);
      recover();
      // class 2 during a class-1 wait: forced zero-speed stop
      set_speed(16'd1000);
      fault1Pin <= 1'b1;
      repeat (10) @(posedge core_clk);
      fault2Pin <= 1'b1;
      wait_drv(2, 1'b1, 6, n);
      check(n < 6, 1'b1);
      check(drive[4:3], 2'b11);
      set_speed(16'd20);
      repeat (20) @(posedge core_clk);
      check(drive[4], 1'b1);
      set_speed(16'd19);
      wait_drv(4, 1'b0, 4, n);
      check(n < 4, 1'b1);
      check(drive[3], 1'b1);
      wait_drv(3, 1'b0, 60, n);
      check(n >= 28 && n <= 34, 1'b1);
      check(drive[4:2], 3'b000);
      recover();
      // no brake function: a class-2 fault de-energises at once
      ahb_write(32'h0000_0000, 32'h0000_0002);
      fault2Pin <= 1'b1;
      wait_drv(3, 1'b0, 6, n);
      check(n < 6, 1'b1);
      check(drive[2], 1'b0);
      close_out();
   end
endmodule : fbs_fault_brake_sequencer_tb_top
